// file: ner_consts.svh
/*
  Offsets, field positions and reset values of the NAND ECC error report block.
  Assumes byte addresses on an 8-bit register port with 32-bit words.
*/
`ifndef NER_CONSTS_SVH
`define NER_CONSTS_SVH
`define NER_OFF_MODE 8'h00
`define NER_OFF_STATUS 8'h04
`define NER_OFF_LOCATOR 8'h08
`define NER_OFF_CODE 8'h0C
`define NER_OFF_IRQ_STAT 8'h10
`define NER_OFF_IRQ_MASK 8'h14
`define NER_OFF_POS_BASE 8'h20
`define NER_OFF_POS_LAST 8'h3C
`define NER_GRAN_LSB 4
`define NER_GRP_W 4
`define NER_GRP_REC 0
`define NER_GRP_CHK 1
`define NER_GRP_MUL 2
`define NER_RSVD_MASK 32'h88888888
`define NER_MUL_MASK 32'h44444444
`define NER_LOC_W 16
`define NER_CODE_W 16
`define NER_GRAN_RST 2'h0
`define NER_IRQ_W 4
`define NER_IRQ_DONE 0
`define NER_IRQ_REC 1
`define NER_IRQ_MUL 2
`define NER_IRQ_CHK 3
`endif

// file: ner_pkg.sv
/*
  Types of the NAND ECC error report block.
  Assumes the check engine on the same clock delivers one result per code.
*/
package ner_pkg;
  typedef enum logic [1:0] {
    NER_GRAN_PAGE = 2'h0,
    NER_GRAN_256 = 2'h1,
    NER_GRAN_512 = 2'h2
  } ner_gran_t;
  typedef enum logic [3:0] {
    NER_K_NONE = 4'h1,
    NER_K_DATA = 4'h2,
    NER_K_CHK = 4'h4,
    NER_K_MULTI = 4'h8
  } ner_kind_t;
  typedef enum logic [1:0] {
    NER_S_IDLE = 2'h1,
    NER_S_COLLECT = 2'h2
  } ner_state_t;
  typedef struct packed {
    logic valid;
    logic [3:0] seg;
    ner_kind_t kind;
    logic [11:0] word;
    logic [3:0] bit_ofs;
    logic [31:0] pos;
    logic [15:0] code;
  } ner_result_t;
endpackage : ner_pkg

// file: ner_top.sv
/*
  NAND ECC error report: collects check results of one page read in a shadow
  set and publishes status, locator and code registers at page end.
  Assumes a check engine on i_ref_clk that brackets each page read with
  start and end pulses and gives one classified result per code.
*/
`timescale 1ns/1ns
`include "ner_consts.svh"
module ner_top import ner_pkg::*; #(
  parameter int SEGS = 8,
  parameter int POS_W = 24
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Check engine
  input wire logic i_page_start,
  input wire logic i_page_end,
  input wire ner_result_t i_res,
  // Interrupt
  output logic o_irq
);
  if (SEGS != 8 || POS_W != 24) begin : g_chk
    $error("ner_top serves eight upper segments with 24-bit positions only");
  end

  ner_state_t state_reg, state_next;
  ner_gran_t gran_reg, gran_next;
  logic [31:0] shd_stat_reg, shd_stat_next;
  logic [31:0] shd_loc_reg, shd_loc_next;
  logic [31:0] shd_code_reg, shd_code_next;
  logic [POS_W-1:0] shd_pos_reg [SEGS];
  logic [POS_W-1:0] shd_pos_next [SEGS];
  logic [31:0] stat_reg, stat_next;
  logic [31:0] loc_reg, loc_next;
  logic [31:0] code_reg, code_next;
  logic [POS_W-1:0] pos_reg [SEGS];
  logic [POS_W-1:0] pos_next [SEGS];
  logic [`NER_IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [`NER_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [`NER_IRQ_W-1:0] evt;
  // Whole-page errors have no status bits, so these carry them to the interrupt
  logic [`NER_IRQ_W-1:0] shd_evt_reg, shd_evt_next;
  logic [31:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  logic take, commit, seg_hit, page_hit;
  logic [2:0] idx;
  logic [4:0] grp;

  assign take = (state_reg == NER_S_COLLECT) && i_res.valid && !i_page_start;
  assign commit = (state_reg == NER_S_COLLECT) && i_page_end && !i_page_start;
  assign seg_hit = take && (gran_reg == NER_GRAN_256) && i_res.seg[3];
  assign page_hit = take && (gran_reg == NER_GRAN_PAGE);
  assign idx = i_res.seg[2:0];
  assign grp = {idx, 2'b00};

  // Shadow collection and page commit
  always_comb begin
    state_next = state_reg;
    shd_stat_next = shd_stat_reg;
    shd_loc_next = shd_loc_reg;
    shd_code_next = shd_code_reg;
    shd_pos_next = shd_pos_reg;
    stat_next = stat_reg;
    loc_next = loc_reg;
    code_next = code_reg;
    pos_next = pos_reg;
    shd_evt_next = shd_evt_reg;
    evt = '0;
    if (i_page_start) begin
      state_next = NER_S_COLLECT;
      shd_stat_next = '0;
      shd_loc_next = '0;
      shd_code_next = '0;
      shd_evt_next = '0;
      for (int i = 0; i < SEGS; i++) begin
        shd_pos_next[i] = '0;
      end
    end
    if (seg_hit) begin
      case (i_res.kind)
        NER_K_DATA: begin
          shd_stat_next[grp + `NER_GRP_REC] = 1'b1;
        end
        NER_K_CHK: begin
          shd_stat_next[grp + `NER_GRP_CHK] = 1'b1;
          shd_pos_next[idx] = i_res.pos[POS_W-1:0];
        end
        NER_K_MULTI: begin
          shd_stat_next[grp + `NER_GRP_REC] = 1'b1;
          shd_stat_next[grp + `NER_GRP_MUL] = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (page_hit) begin
      shd_code_next = {16'h0000, i_res.code};
      case (i_res.kind)
        NER_K_DATA: begin
          shd_loc_next = {16'h0000, i_res.word, i_res.bit_ofs};
          shd_evt_next[`NER_IRQ_REC] = 1'b1;
        end
        NER_K_CHK: begin
          shd_loc_next = {16'h0000, i_res.pos[15:0]};
          shd_code_next = {16'h0000, i_res.pos[31:16]};
          shd_evt_next[`NER_IRQ_REC] = 1'b1;
          shd_evt_next[`NER_IRQ_CHK] = 1'b1;
        end
        NER_K_MULTI: begin
          // Locator left as is: meaningless after multiple errors
          shd_evt_next[`NER_IRQ_REC] = 1'b1;
          shd_evt_next[`NER_IRQ_MUL] = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (commit) begin
      state_next = NER_S_IDLE;
      stat_next = (gran_reg == NER_GRAN_256) ? (shd_stat_reg & ~`NER_RSVD_MASK) : '0;
      loc_next = shd_loc_reg;
      code_next = shd_code_reg;
      pos_next = shd_pos_reg;
      evt[`NER_IRQ_DONE] = 1'b1;
      evt[`NER_IRQ_REC] = |stat_next || shd_evt_reg[`NER_IRQ_REC];
      evt[`NER_IRQ_MUL] = |(stat_next & `NER_MUL_MASK) || shd_evt_reg[`NER_IRQ_MUL];
      evt[`NER_IRQ_CHK] = |(stat_next & (`NER_MUL_MASK >> 1)) || shd_evt_reg[`NER_IRQ_CHK];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= NER_S_IDLE;
      shd_stat_reg <= '0;
      shd_loc_reg <= '0;
      shd_code_reg <= '0;
      shd_evt_reg <= '0;
      stat_reg <= '0;
      loc_reg <= '0;
      code_reg <= '0;
      for (int i = 0; i < SEGS; i++) begin
        shd_pos_reg[i] <= '0;
        pos_reg[i] <= '0;
      end
    end else begin
      state_reg <= state_next;
      shd_stat_reg <= shd_stat_next;
      shd_loc_reg <= shd_loc_next;
      shd_code_reg <= shd_code_next;
      shd_evt_reg <= shd_evt_next;
      stat_reg <= stat_next;
      loc_reg <= loc_next;
      code_reg <= code_next;
      shd_pos_reg <= shd_pos_next;
      pos_reg <= pos_next;
    end
  end

  // Register port, interrupt and read data
  always_comb begin
    gran_next = gran_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    rdata_next = '0;
    if (i_wr && i_addr == `NER_OFF_MODE) begin
      if (i_wdata[`NER_GRAN_LSB +: 2] != 2'h3) begin
        gran_next = ner_gran_t'(i_wdata[`NER_GRAN_LSB +: 2]);
      end
    end else if (i_wr && i_addr == `NER_OFF_IRQ_MASK) begin
      irq_mask_next = i_wdata[`NER_IRQ_W-1:0];
    end else if (i_wr && i_addr == `NER_OFF_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~i_wdata[`NER_IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    irq_stat_next = irq_stat_next | evt;
    irq_next = |(irq_stat_next & irq_mask_next);
    if (i_rd) begin
      if (i_addr == `NER_OFF_MODE) begin
        rdata_next[`NER_GRAN_LSB +: 2] = gran_reg;
      end else if (i_addr == `NER_OFF_STATUS) begin
        rdata_next = stat_reg;
      end else if (i_addr == `NER_OFF_LOCATOR) begin
        rdata_next = loc_reg;
      end else if (i_addr == `NER_OFF_CODE) begin
        rdata_next = code_reg;
      end else if (i_addr == `NER_OFF_IRQ_STAT) begin
        rdata_next[`NER_IRQ_W-1:0] = irq_stat_reg;
      end else if (i_addr == `NER_OFF_IRQ_MASK) begin
        rdata_next[`NER_IRQ_W-1:0] = irq_mask_reg;
      end else if (i_addr >= `NER_OFF_POS_BASE && i_addr <= `NER_OFF_POS_LAST && i_addr[1:0] == 2'b00) begin
        rdata_next[POS_W-1:0] = pos_reg[i_addr[4:2]];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gran_reg <= ner_gran_t'(`NER_GRAN_RST);
      irq_mask_reg <= '0;
      irq_stat_reg <= '0;
      rdata_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      gran_reg <= gran_next;
      irq_mask_reg <= irq_mask_next;
      irq_stat_reg <= irq_stat_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_irq = irq_reg;

  // Checks; helper flop keeps the status group offset of the previous cycle's result
  logic [4:0] hit_grp_reg;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hit_grp_reg <= '0;
    end else begin
      hit_grp_reg <= grp;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);

  property p_gran_zero;
    commit && gran_reg != NER_GRAN_256 |=> stat_reg == 32'h0 [*2];
  endproperty
  a_gran_zero: assert property (p_gran_zero) else $error("upper flags set outside 256 mode");

  property p_rec_set;
    seg_hit && i_res.kind == NER_K_DATA |=> shd_stat_reg[hit_grp_reg + `NER_GRP_REC];
  endproperty
  a_rec_set: assert property (p_rec_set) else $error("recoverable flag not set");

  property p_chk_set;
    seg_hit && i_res.kind == NER_K_CHK |=> shd_stat_reg[hit_grp_reg + `NER_GRP_CHK] && $onehot(shd_pos_reg[hit_grp_reg[4:2]]);
  endproperty
  a_chk_set: assert property (p_chk_set) else $error("check-byte flag or position wrong");

  property p_pos_onehot;
    commit && gran_reg == NER_GRAN_256 && shd_stat_reg[`NER_GRP_CHK] |=> $onehot(pos_reg[0]);
  endproperty
  a_pos_onehot: assert property (p_pos_onehot) else $error("check position not one-hot");

  property p_mul_clear;
    i_page_start |=> shd_stat_reg == 32'h0;
  endproperty
  a_mul_clear: assert property (p_mul_clear) else $error("flags not cleared at page start");

  property p_lower_ignored;
    take && !i_res.seg[3] && gran_reg == NER_GRAN_256 && !i_page_end |=> $stable(shd_stat_reg);
  endproperty
  a_lower_ignored: assert property (p_lower_ignored) else $error("lower segment changed upper flags");

  property p_rsvd_zero;
    (stat_reg & `NER_RSVD_MASK) == 32'h0 && ((stat_reg & `NER_MUL_MASK) >> 2 & ~stat_reg) == 32'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit or lone multiple flag");

  property p_locator;
    page_hit && i_res.kind == NER_K_DATA && !i_page_end
      |=> shd_loc_reg[15:0] == {$past(i_res.word), $past(i_res.bit_ofs)};
  endproperty
  a_locator: assert property (p_locator) else $error("bit or word locator wrong");

  property p_upper_zero;
    loc_reg[31:16] == 16'h0 && code_reg[31:16] == 16'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("reserved result bits set");

  property p_page_chk;
    page_hit && i_res.kind == NER_K_CHK && $onehot(i_res.pos) |=> $onehot({shd_code_reg[15:0], shd_loc_reg[15:0]});
  endproperty
  a_page_chk: assert property (p_page_chk) else $error("page check-byte not one-hot");

  property p_atomic;
    !commit |=> $stable(stat_reg) && $stable(loc_reg) && $stable(code_reg);
  endproperty
  a_atomic: assert property (p_atomic) else $error("results changed outside commit");

  c_multi: cover property (seg_hit && i_res.kind == NER_K_MULTI ##[1:50] commit);
  c_page_single: cover property (page_hit && i_res.kind == NER_K_DATA ##[1:50] commit);
  c_irq: cover property (commit ##2 o_irq);
endmodule : ner_top

// file: ner_engine_model.sv
/*
  Check engine model: page bracket pulses and one classified result per call.
  Assumes a single bench process calls go, one operation per cycle.
*/
`timescale 1ns/1ns
module ner_engine_model import ner_pkg::*; (
  // Clock
  input wire logic i_ref_clk,
  // Engine side
  output logic o_page_start,
  output logic o_page_end,
  output ner_result_t o_res
);
  logic [1:0] op = 2'h0;
  ner_result_t nxt;
  initial begin
    o_page_start = 1'b0;
    o_page_end = 1'b0;
    o_res = '0;
  end
  // Idle fields keep toggling so stale data can never pass as a result
  always @(posedge i_ref_clk) begin
    o_page_start <= (op == 2'h1);
    o_page_end <= (op == 2'h3);
    o_res <= (op == 2'h2) ? nxt : {1'b0, ~o_res[71:0]};
  end
  task automatic go(input logic [1:0] o, input ner_result_t r);
    @(negedge i_ref_clk);
    op = o;
    nxt = r;
    @(posedge i_ref_clk);
    #1;
    op = 2'h0;
  endtask : go
endmodule : ner_engine_model

// file: test_nand_ecc_error_report.sv
/*
  Self-checking bench of the NAND ECC error report block.
  Assumes one 125 MHz clock and the engine model beside the design.
*/
`timescale 1ns/1ns
`include "ner_consts.svh"
module test_nand_ecc_error_report;
  import ner_pkg::*;
  logic clk, arst_n, wr, rd, irq, pstart, pend;
  logic rd_q = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, pos;
  logic [11:0] w;
  logic [3:0] b;
  logic [15:0] cw;
  ner_result_t res;
  logic [31:0] exp_q[$];
  int fail_count = 0;
  int check_count = 0;
  int seed = 28;
  ner_top #(.SEGS(8), .POS_W(24)) ner_top_inst (.i_ref_clk(clk), .i_arst_n(arst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_page_start(pstart), .i_page_end(pend),
    .i_res(res), .o_irq(irq));
  ner_engine_model ner_engine_model_inst (.i_ref_clk(clk), .o_page_start(pstart), .o_page_end(pend),
    .o_res(res));
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, e, s);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic send(input logic [3:0] s, input ner_kind_t k, input logic [31:0] p);
    w = 12'($random(seed));
    b = 4'($random(seed));
    cw = 16'($random(seed));
    ner_engine_model_inst.go(2'h2, '{1'b1, s, k, w, b, p, cw});
  endtask : send
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_q && exp_q.size() > 0) chk("rdata", exp_q.pop_front(), rdata);
    else if (!rd_q && arst_n) chk("rdata idle", 32'h0, rdata);
    rd_q <= rd;
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    summarize();
  end
  initial begin
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(`NER_OFF_STATUS, 32'h0);
    rd_reg(`NER_OFF_LOCATOR, 32'h0);
    rd_reg(`NER_OFF_CODE, 32'h0);
    rd_reg(8'h18, 32'h0);
    wr_reg(`NER_OFF_MODE, 32'h10);
    wr_reg(`NER_OFF_MODE, 32'h30);
    rd_reg(`NER_OFF_MODE, 32'h10);
    wr_reg(`NER_OFF_IRQ_MASK, 32'hF);
    pos = 32'h1 << ($unsigned($random(seed)) % 24);
    ner_engine_model_inst.go(2'h1, '0);
    send(4'h8, NER_K_DATA, 32'h0);
    send(4'h9, NER_K_MULTI, 32'h0);
    send(4'hF, NER_K_CHK, pos);
    send(4'h8, NER_K_CHK, pos);
    send(4'h3, NER_K_DATA, 32'h0);
    rd_reg(`NER_OFF_STATUS, 32'h0);
    ner_engine_model_inst.go(2'h3, '0);
    rd_reg(`NER_OFF_STATUS, 32'h2000_0053);
    rd_reg(`NER_OFF_POS_LAST, pos);
    rd_reg(`NER_OFF_POS_BASE, pos);
    rd_reg(`NER_OFF_IRQ_STAT, 32'hF);
    chk("irq", 32'h1, {31'h0, irq});
    wr_reg(`NER_OFF_IRQ_STAT, 32'hF);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    ner_engine_model_inst.go(2'h1, '0);
    send(4'hA, NER_K_DATA, 32'h0);
    rd_reg(`NER_OFF_STATUS, 32'h2000_0053);
    ner_engine_model_inst.go(2'h3, '0);
    rd_reg(`NER_OFF_STATUS, 32'h0000_0100);
    wr_reg(`NER_OFF_MODE, 32'h00);
    ner_engine_model_inst.go(2'h1, '0);
    send(4'h9, NER_K_DATA, 32'h0);
    ner_engine_model_inst.go(2'h3, '0);
    rd_reg(`NER_OFF_STATUS, 32'h0);
    rd_reg(`NER_OFF_LOCATOR, {16'h0, w, b});
    rd_reg(`NER_OFF_CODE, {16'h0, cw});
    pos = 32'h1 << ($unsigned($random(seed)) % 32);
    ner_engine_model_inst.go(2'h1, '0);
    send(4'hF, NER_K_CHK, pos);
    ner_engine_model_inst.go(2'h3, '0);
    rd_reg(`NER_OFF_STATUS, 32'h0);
    rd_reg(`NER_OFF_LOCATOR, {16'h0, pos[15:0]});
    rd_reg(`NER_OFF_CODE, {16'h0, pos[31:16]});
    rd_reg(`NER_OFF_IRQ_STAT, 32'hB);
    wr_reg(`NER_OFF_MODE, 32'h20);
    rd_reg(`NER_OFF_MODE, 32'h20);
    ner_engine_model_inst.go(2'h1, '0);
    send(4'h9, NER_K_MULTI, 32'h0);
    ner_engine_model_inst.go(2'h3, '0);
    rd_reg(`NER_OFF_STATUS, 32'h0);
    for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(posedge clk);
    if (exp_q.size() > 0) begin
      fail_count++;
      $display("[FAIL] rdata expected %0d reads seen none", exp_q.size());
    end
    summarize();
  end
endmodule : test_nand_ecc_error_report
